// >>> src/pim_cfg.svh
// constants for the pulse input measurement block: timing, register map, fields
`ifndef PIM_CFG_SVH
`define PIM_CFG_SVH

`define CLK_HZ    100000000
`define TICK_MS   1
`define TMO_S     10
`define NCH       8
`define LOWF_HZ   16'h0032
`define DUTY_FULL 14'h2710
`define DIV_LAST  5'h0F

`define A_CFG     3'h0
`define A_WIN     3'h1
`define A_MAX     3'h2
`define A_PER     3'h3
`define A_HIGH    3'h4
`define A_DUTY    3'h5
`define A_MEAS    3'h6
`define A_STAT    3'h7
`define A_GLB     7'h40

`define F_MODE    1:0
`define F_PPR     15:8
`define F_W16     15:0
`define G_CLR     0

`endif

// >>> src/pim_pkg.sv
// types shared by the pulse input measurement block
`default_nettype none
package pim_pkg;

  typedef enum logic [1:0] {
    M_OFF  = 2'b00,
    M_DUTY = 2'b01,
    M_FREQ = 2'b10,
    M_CNT  = 2'b11
  } mode_t;

  typedef struct packed {
    logic meta;
    logic lvl;
    logic prev;
  } sync_t;

endpackage
`default_nettype wire

// >>> src/pin_sync.sv
// input conditioner: two-flop synchroniser and rising edge detector
`default_nettype none
module pin_sync
  import pim_pkg::*;
(
  input  wire logic clk,
  input  wire logic nrst,
  input  wire logic ce,
  input  wire logic pin,
  output logic      lvl,
  output logic      rise
);

  sync_t s_q;
  sync_t s_d;

  // meta feeds only the second stage
  always_comb begin
    s_d      = s_q;
    s_d.meta = pin;
    s_d.lvl  = s_q.meta;
    s_d.prev = s_q.lvl;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s_q <= '0;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  assign lvl  = s_q.lvl;
  assign rise = s_q.lvl & ~s_q.prev;

  property p_rise_single;
    @(posedge clk) disable iff (!nrst) ce && rise |=> !rise;
  endproperty
  a_rise_single: assert property (p_rise_single) else $error("rise lasted two cycles");

endmodule
`default_nettype wire

// >>> src/pulse_input_measurement.sv
// pulse input measurement: eight channels, register file and shared duty divider
`include "pim_cfg.svh"
`default_nettype none
// How it works
// - eight channels, each configured alone, any may run duty-cycle mode.
// - duty mode covers fifty hertz to ten kilohertz input signals.
// - duty reported across zero to one hundred percent.
// - duty value is in percent of high time, hundredths per bit.
// - maximum setpoint at or below 50 Hz: time rising edges, ignore window.
// - in edge timing, no rising edge for ten seconds zeroes the value; a duty line held high reads full duty.
// - edge timing covers 0.1 to 50 Hz with two-decimal resolution.
// - frequency mode counts pulses over one measuring window.
// - pulses per revolution zero means results are in hertz.
// - non-zero pulses per revolution means results are in RPM.
// - every channel can act as a 16-bit counter.
// - counter counts pulses to the window value, then captures a millisecond timer.
// - after capture the millisecond timer clears and runs again.
// - counter mode applies no range or error thresholds.
// - a counter channel never serves as control or enable source.
module pulse_input_measurement
  import pim_pkg::*;
#(
  parameter int MS_CYC  = `CLK_HZ / 1000 * `TICK_MS,
  parameter int TMO_CYC = `TMO_S * `CLK_HZ
) (
  input  wire logic          clk,
  input  wire logic          nrst,
  input  wire logic          ce,
  input  wire logic [7:0]    pulse_in,
  input  wire logic [6:0]    avs_address,
  input  wire logic          avs_read,
  input  wire logic          avs_write,
  input  wire logic [31:0]   avs_writedata,
  input  wire logic [3:0]    avs_byteenable,
  output logic      [31:0]   avs_readdata,
  output logic               avs_waitrequest,
  output logic      [7:0]    ctrl_ok
);

  typedef struct packed {
    logic                       ack;
    logic [31:0]                rdata;
    logic [16:0]                pre;
    mode_t [`NCH-1:0]           mode;
    logic [`NCH-1:0][7:0]       ppr;
    logic [`NCH-1:0][15:0]      win;
    logic [`NCH-1:0][15:0]      maxsp;
    logic [`NCH-1:0][29:0]      pcnt;
    logic [`NCH-1:0][29:0]      hcnt;
    logic [`NCH-1:0][29:0]      per;
    logic [`NCH-1:0][29:0]      hi;
    logic [`NCH-1:0][15:0]      pul;
    logic [`NCH-1:0][15:0]      ms;
    logic [`NCH-1:0][15:0]      meas;
    logic [`NCH-1:0][13:0]      duty;
    logic [`NCH-1:0]            armed;
    logic [`NCH-1:0]            stale;
    logic [2:0]                 dch;
    logic [4:0]                 dbit;
    logic                       dbusy;
    logic [30:0]                drem;
    logic [15:0]                dq;
  } st_t;

  st_t              s_q;
  st_t              s_d;
  logic             tick;
  logic             clr;
  logic             wr;
  logic [2:0]       ch;
  logic [2:0]       dc;
  logic [31:0]      w;
  logic [31:0]      rdv;
  logic [30:0]      rem2;
  logic             ge;
  logic [29:0]      prod;
  logic [`NCH-1:0]  lowf;
  logic [`NCH-1:0]  edge_m;
  logic [`NCH-1:0]  cnt_mask;
  logic [`NCH-1:0]  cap_c;
  logic [`NCH-1:0]  cap_w;
  logic [`NCH-1:0]  rise;
  logic [`NCH-1:0]  lvl;

  function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] nw,
                                           input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return r;
  endfunction

  // a window of zero behaves as one so the channel never stalls
  function automatic logic [15:0] win_eff(input logic [15:0] v);
    return (v == 16'h0) ? 16'h1 : v;
  endfunction

  function automatic logic [15:0] inc16(input logic [15:0] v, input logic en);
    return (en && v != 16'hFFFF) ? v + 16'h1 : v;
  endfunction

  genvar gi;
  generate
    for (gi = 0; gi < `NCH; gi++) begin : g_pin
      pin_sync u_sync (
        .clk  (clk),
        .nrst (nrst),
        .ce   (ce),
        .pin  (pulse_in[gi]),
        .lvl  (lvl[gi]),
        .rise (rise[gi])
      );
    end
  endgenerate

  always_comb begin
    s_d      = s_q;
    w        = 32'h0;
    rdv      = 32'h0;
    rem2     = 31'h0;
    ge       = 1'b0;
    prod     = 30'h0;
    lowf     = 8'h0;
    edge_m   = 8'h0;
    cnt_mask = 8'h0;
    cap_c    = 8'h0;
    cap_w    = 8'h0;
    ch       = avs_address[5:3];
    dc       = s_q.dch;

    // bus: one wait cycle, then the answer; write lands on the releasing edge
    s_d.ack = (avs_read | avs_write) & ~s_q.ack;
    wr      = avs_write && s_q.ack;
    clr     = wr && avs_address == `A_GLB && avs_byteenable[0] && avs_writedata[`G_CLR];

    if (wr && !avs_address[6]) begin
      case (avs_address[2:0])
        `A_CFG: begin
          w = be_merge({16'h0, s_q.ppr[ch], 6'h0, s_q.mode[ch]}, avs_writedata, avs_byteenable);
          s_d.mode[ch] = mode_t'(w[`F_MODE]);
          s_d.ppr[ch]  = w[`F_PPR];
        end
        `A_WIN: begin
          w = be_merge({16'h0, s_q.win[ch]}, avs_writedata, avs_byteenable);
          s_d.win[ch] = w[`F_W16];
        end
        `A_MAX: begin
          w = be_merge({16'h0, s_q.maxsp[ch]}, avs_writedata, avs_byteenable);
          s_d.maxsp[ch] = w[`F_W16];
        end
        default: begin
        end
      endcase
    end

    // shared millisecond prescaler
    tick = !clr && s_q.pre == 17'(MS_CYC - 1);
    if (clr || tick) begin
      s_d.pre = 17'h0;
    end else begin
      s_d.pre = s_q.pre + 17'h1;
    end

    // one serial divider visits duty channels in turn: 17 cycles per result
    // instead of eight parallel dividers; duty refresh lags by up to ~140 cycles
    if (!s_q.dbusy) begin
      s_d.dch = s_q.dch + 3'h1;
      if (s_q.mode[dc] == M_DUTY && s_q.per[dc] != 30'h0) begin
        if (s_q.hi[dc] >= s_q.per[dc]) begin
          s_d.duty[dc] = `DUTY_FULL;
        end else begin
          s_d.dch   = s_q.dch;
          s_d.dbusy = 1'b1;
          s_d.dbit  = 5'h0;
          s_d.drem  = {1'b0, s_q.hi[dc]};
          s_d.dq    = 16'h0;
        end
      end
    end else if (s_q.mode[dc] != M_DUTY || s_q.per[dc] == 30'h0) begin
      s_d.dbusy = 1'b0;
      s_d.dch   = s_q.dch + 3'h1;
    end else begin
      rem2      = {s_q.drem[29:0], 1'b0};
      ge        = rem2 >= {1'b0, s_q.per[dc]};
      s_d.drem  = ge ? rem2 - {1'b0, s_q.per[dc]} : rem2;
      s_d.dq    = {s_q.dq[14:0], ge};
      s_d.dbit  = s_q.dbit + 5'h1;
      if (s_q.dbit == `DIV_LAST) begin
        // binary fraction scaled to hundredths of a percent of high time
        prod         = {14'h0, s_d.dq} * {16'h0, `DUTY_FULL};
        s_d.duty[dc] = prod[29:16];
        s_d.dbusy    = 1'b0;
        s_d.dch      = s_q.dch + 3'h1;
      end
    end

    for (int i = 0; i < `NCH; i++) begin
      lowf[i]     = s_q.maxsp[i] <= `LOWF_HZ;
      edge_m[i]   = s_q.mode[i] == M_DUTY || (s_q.mode[i] == M_FREQ && lowf[i]);
      cnt_mask[i] = s_q.mode[i] == M_CNT;

      if (clr || s_d.mode[i] != s_q.mode[i]) begin
        s_d.pcnt[i]  = 30'h0;
        s_d.hcnt[i]  = 30'h0;
        s_d.per[i]   = 30'h0;
        s_d.hi[i]    = 30'h0;
        s_d.pul[i]   = 16'h0;
        s_d.ms[i]    = 16'h0;
        s_d.meas[i]  = 16'h0;
        s_d.duty[i]  = 14'h0;
        s_d.armed[i] = 1'b0;
        s_d.stale[i] = 1'b0;
      end else if (edge_m[i]) begin
        // edge timing: period and high time in 10 ns cycles, 30 bits reach 10 s
        s_d.pul[i] = 16'h0;
        s_d.ms[i]  = 16'h0;
        if (rise[i]) begin
          if (s_q.armed[i]) begin
            s_d.per[i]   = s_q.pcnt[i];
            s_d.hi[i]    = s_q.hcnt[i];
            s_d.stale[i] = 1'b0;
          end
          s_d.armed[i] = 1'b1;
          s_d.pcnt[i]  = 30'h1;
          s_d.hcnt[i]  = 30'h1;
        end else if (s_q.pcnt[i] >= 30'(TMO_CYC)) begin
          // silent line: zero the value; a line stuck high reads as full duty
          s_d.per[i]   = 30'h0;
          s_d.hi[i]    = 30'h0;
          s_d.stale[i] = 1'b1;
          s_d.armed[i] = 1'b0;
          s_d.duty[i]  = lvl[i] ? `DUTY_FULL : 14'h0;
        end else begin
          s_d.pcnt[i] = s_q.pcnt[i] + 30'h1;
          s_d.hcnt[i] = s_q.hcnt[i] + {29'h0, lvl[i]};
        end
      end else if (s_q.mode[i] == M_FREQ) begin
        // pulses per window; firmware scales to Hz or RPM by the unit flag
        if (tick && s_q.ms[i] + 16'h1 >= win_eff(s_q.win[i])) begin
          s_d.meas[i] = inc16(s_q.pul[i], rise[i]);
          s_d.pul[i]  = 16'h0;
          s_d.ms[i]   = 16'h0;
          cap_w[i]    = 1'b1;
        end else begin
          s_d.pul[i] = inc16(s_q.pul[i], rise[i]);
          s_d.ms[i]  = inc16(s_q.ms[i], tick);
        end
      end else if (s_q.mode[i] == M_CNT) begin
        // no range or error checking in this mode: raw milliseconds only
        s_d.ms[i] = inc16(s_q.ms[i], tick);
        if (rise[i] && s_q.pul[i] + 16'h1 >= win_eff(s_q.win[i])) begin
          // a tick on the capture edge belongs to the interval just closed, or one ms is lost
          s_d.meas[i] = inc16(s_q.ms[i], tick);
          s_d.ms[i]   = 16'h0;
          s_d.pul[i]  = 16'h0;
          cap_c[i]    = 1'b1;
        end else begin
          s_d.pul[i] = inc16(s_q.pul[i], rise[i]);
        end
      end
    end

    if (avs_read && !s_q.ack) begin
      if (!avs_address[6]) begin
        case (avs_address[2:0])
          `A_CFG:  rdv = {16'h0, s_q.ppr[ch], 6'h0, s_q.mode[ch]};
          `A_WIN:  rdv = {16'h0, s_q.win[ch]};
          `A_MAX:  rdv = {16'h0, s_q.maxsp[ch]};
          `A_PER:  rdv = {2'h0, s_q.per[ch]};
          `A_HIGH: rdv = {2'h0, s_q.hi[ch]};
          `A_DUTY: rdv = {18'h0, s_q.duty[ch]};
          `A_MEAS: rdv = {16'h0, s_q.meas[ch]};
          `A_STAT: rdv = {28'h0, ctrl_ok[ch],
                          s_q.mode[ch] == M_FREQ && s_q.ppr[ch] != 8'h0,
                          s_q.stale[ch], edge_m[ch]};
          default: rdv = 32'h0;
        endcase
      end
      s_d.rdata = rdv;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s_q <= '0;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  assign avs_readdata    = s_q.rdata;
  assign avs_waitrequest = (avs_read | avs_write) & ~s_q.ack;

  generate
    for (gi = 0; gi < `NCH; gi++) begin : g_ok
      // counters and idle channels are never offered as control or enable
      assign ctrl_ok[gi] = s_q.mode[gi] == M_DUTY || s_q.mode[gi] == M_FREQ;
    end
  endgenerate

  property p_ctrl_ok;
    @(posedge clk) disable iff (!nrst) (ctrl_ok & cnt_mask) == 8'h0 && (ctrl_ok | cnt_mask) != 8'h0
      || s_q.mode == '0;
  endproperty
  a_ctrl_ok: assert property (p_ctrl_ok) else $error("counter channel offered as control");

  property p_mode_clr;
    @(posedge clk) disable iff (!nrst)
      $changed(s_q.mode[4]) |-> s_q.meas[4] == 16'h0 && s_q.pul[4] == 16'h0 && s_q.per[4] == 30'h0;
  endproperty
  a_mode_clr: assert property (p_mode_clr) else $error("mode change left old state");

  property p_soft_clr;
    @(posedge clk) disable iff (!nrst) ce && clr |=> s_q.meas == '0 && s_q.per == '0 && s_q.pre == 17'h0;
  endproperty
  a_soft_clr: assert property (p_soft_clr) else $error("clear did not empty measurement");

  property p_timeout;
    @(posedge clk) disable iff (!nrst) s_q.stale[1] |-> s_q.per[1] == 30'h0 && s_q.hi[1] == 30'h0;
  endproperty
  a_timeout: assert property (p_timeout) else $error("stale channel kept a value");

  property p_cnt_cap;
    @(posedge clk) disable iff (!nrst)
      ce && cap_c[4] |=> s_q.meas[4] == $past(inc16(s_q.ms[4], tick)) && s_q.pul[4] == 16'h0;
  endproperty
  a_cnt_cap: assert property (p_cnt_cap) else $error("counter capture wrong");

  property p_cnt_restart;
    @(posedge clk) disable iff (!nrst) ce && cap_c[4] ##1 ce |=> s_q.ms[4] <= 16'h1;
  endproperty
  a_cnt_restart: assert property (p_cnt_restart) else $error("timer not restarted");

  property p_win_cap;
    @(posedge clk) disable iff (!nrst)
      ce && cap_w[2] && !rise[2] && s_q.pul[2] != 16'hFFFF |=> s_q.meas[2] == $past(s_q.pul[2]);
  endproperty
  a_win_cap: assert property (p_win_cap) else $error("window count wrong");

  property p_lowf;
    @(posedge clk) disable iff (!nrst) ce && edge_m[3] |=> s_q.pul[3] == 16'h0 && s_q.ms[3] == 16'h0;
  endproperty
  a_lowf: assert property (p_lowf) else $error("window used in edge timing");

  property p_duty_range;
    @(posedge clk) disable iff (!nrst) s_q.duty[1] <= `DUTY_FULL;
  endproperty
  a_duty_range: assert property (p_duty_range) else $error("duty above full scale");

  property p_wait;
    @(posedge clk) disable iff (!nrst) ce && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  a_wait: assert property (p_wait) else $error("waitrequest held two cycles");

  c_cnt_cap: cover property (@(posedge clk) disable iff (!nrst) cap_c[4]);
  c_win_cap: cover property (@(posedge clk) disable iff (!nrst) cap_w[2]);
  c_stale: cover property (@(posedge clk) disable iff (!nrst) $rose(s_q.stale[1]));
  c_duty: cover property (@(posedge clk) disable iff (!nrst) $fell(s_q.dbusy) && s_q.duty[1] != 14'h0);

endmodule
`default_nettype wire

// >>> verification/pulse_gen.sv
// partner model: external controller driving one pulse line
`default_nettype none
module pulse_gen (
  input  wire logic        clk,
  input  wire logic        en,
  input  wire logic        idle,
  input  wire logic [15:0] per,
  input  wire logic [15:0] hi,
  output var  logic        pin
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] cnt = 16'h0000;
  initial pin = 1'b0;
  // a stopped line rests at a chosen static level, so 0 % and 100 % can be shown
  always @(posedge clk) begin
    if (en) begin
      pin <= (cnt < hi);
      cnt <= (cnt + 16'h0001 >= per) ? 16'h0000 : cnt + 16'h0001;
    end else begin
      pin <= idle;
      cnt <= 16'h0000;
    end
  end
endmodule
`default_nettype wire

// >>> verification/pulse_input_measurement_test.sv
// self-checking bench for the pulse input measurement block
`include "pim_cfg.svh"
`default_nettype none
module pulse_input_measurement_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk;
  logic        nrst;
  logic        ce;
  wire  [7:0]  pulse_in;
  logic [6:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [3:0]  avs_byteenable;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [7:0]  ctrl_ok;
  logic [7:0]  gen_en;
  logic [7:0]  gen_idle;
  logic [15:0] gen_per [8];
  logic [15:0] gen_hi [8];
  logic [31:0] rd;
  int          err_total = 0;
  int          tests_run = 0;

  for (genvar g = 0; g < 8; g++) begin : g_src
    pulse_gen u_src (.clk(clk), .en(gen_en[g]), .idle(gen_idle[g]), .per(gen_per[g]), .hi(gen_hi[g]),
                     .pin(pulse_in[g]));
  end

  // short ms tick and timeout keep the run small; expectations below follow these values
  pulse_input_measurement #(.MS_CYC(10), .TMO_CYC(200)) DUT (
    .clk(clk), .nrst(nrst), .ce(ce), .pulse_in(pulse_in), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .ctrl_ok(ctrl_ok));

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask

  function automatic logic [6:0] adr(input int ch, input logic [2:0] r);
    return {1'b0, ch[2:0], r};
  endfunction

  // holds the request until waitrequest is sampled low; read data taken at that edge
  task automatic bus_req(input logic [6:0] a, input logic wr, input logic [31:0] d);
    int n;
    @(posedge clk);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= wr;
    avs_read      <= !wr;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    if (avs_waitrequest !== 1'b0) begin
      err_total++;
      $display("Error waitrequest expected 0 seen 1");
      end_sim();
    end
  endtask

  task automatic rd_chk(input string name, input logic [6:0] a, input logic [31:0] exp);
    bus_req(a, 1'b0, 32'h0000_0000);
    check(name, exp, rd);
  endtask

  task automatic stat_bit(input int ch, input int b, input logic exp);
    bus_req(adr(ch, `A_STAT), 1'b0, 32'h0000_0000);
    check("status bit", {31'h0, exp}, {31'h0, rd[b]});
  endtask

  task automatic src(input int ch, input logic en, input logic idle, input logic [15:0] per,
                     input logic [15:0] hi);
    gen_en[ch]   <= en;
    gen_idle[ch] <= idle;
    gen_per[ch]  <= per;
    gen_hi[ch]   <= hi;
  endtask

  task automatic t_reset();
    check("ctrl_ok", 32'h0, {24'h0, ctrl_ok});
    rd_chk("window", adr(0, `A_WIN), 32'h0);
    bus_req(7'h41, 1'b1, 32'hFFFF_FFFF);
    rd_chk("unmapped", 7'h41, 32'h0);
  endtask

  task automatic t_modes();
    for (int ch = 0; ch < 8; ch++) begin
      bus_req(adr(ch, `A_CFG), 1'b1, ch & 3);
      rd_chk("mode", adr(ch, `A_CFG), ch & 3);
      check("ctrl_ok bit", {31'h0, (ch & 3) == 1 || (ch & 3) == 2}, {31'h0, ctrl_ok[ch]});
    end
  endtask

  task automatic t_duty();
    bus_req(adr(1, `A_CFG), 1'b1, 32'h1);
    src(1, 1'b1, 1'b0, 16'h0064, 16'h0019);
    repeat (600) @(posedge clk);
    rd_chk("period", adr(1, `A_PER), 32'h64);
    rd_chk("high", adr(1, `A_HIGH), 32'h19);
    rd_chk("duty", adr(1, `A_DUTY), 32'h9C4);
    src(1, 1'b0, 1'b0, 16'h0064, 16'h0019);
    repeat (400) @(posedge clk);
    rd_chk("duty low", adr(1, `A_DUTY), 32'h0);
    stat_bit(1, 1, 1'b1);
    src(1, 1'b0, 1'b1, 16'h0064, 16'h0019);
    repeat (400) @(posedge clk);
    rd_chk("duty high", adr(1, `A_DUTY), 32'h2710);
  endtask

  task automatic t_freq();
    bus_req(adr(2, `A_WIN), 1'b1, 32'h5);
    bus_req(adr(2, `A_MAX), 1'b1, 32'h3E8);
    src(2, 1'b1, 1'b0, 16'h000A, 16'h0005);
    repeat (200) @(posedge clk);
    rd_chk("pulses", adr(2, `A_MEAS), 32'h5);
    stat_bit(2, 2, 1'b0);
    bus_req(adr(2, `A_CFG), 1'b1, 32'h402);
    stat_bit(2, 2, 1'b1);
    repeat (100) @(posedge clk);
    rd_chk("pulses", adr(2, `A_MEAS), 32'h5);
  endtask

  task automatic t_edge();
    bus_req(adr(3, `A_MAX), 1'b1, 32'h32);
    bus_req(adr(3, `A_CFG), 1'b1, 32'h2);
    src(3, 1'b1, 1'b0, 16'h0096, 16'h0032);
    repeat (700) @(posedge clk);
    stat_bit(3, 0, 1'b1);
    rd_chk("period", adr(3, `A_PER), 32'h96);
    rd_chk("high", adr(3, `A_HIGH), 32'h32);
    bus_req(adr(3, `A_MAX), 1'b1, 32'h33);
    stat_bit(3, 0, 1'b0);
    bus_req(adr(3, `A_MAX), 1'b1, 32'h32);
  endtask

  task automatic t_count();
    bus_req(adr(4, `A_WIN), 1'b1, 32'h4);
    bus_req(adr(4, `A_CFG), 1'b1, 32'h3);
    src(4, 1'b1, 1'b0, 16'h0014, 16'h000A);
    repeat (300) @(posedge clk);
    rd_chk("ms captured", adr(4, `A_MEAS), 32'h8);
    repeat (100) @(posedge clk);
    rd_chk("ms recaptured", adr(4, `A_MEAS), 32'h8);
    check("ctrl_ok bit", 32'h0, {31'h0, ctrl_ok[4]});
    stat_bit(4, 3, 1'b0);
    bus_req(adr(4, `A_CFG), 1'b1, 32'h2);
    rd_chk("cleared", adr(4, `A_MEAS), 32'h0);
  endtask

  task automatic t_clear();
    bus_req(`A_GLB, 1'b1, 32'h1);
    rd_chk("period", adr(3, `A_PER), 32'h0);
    rd_chk("mode kept", adr(3, `A_CFG), 32'h2);
    bus_req(adr(3, `A_PER), 1'b1, 32'h1234);
    rd_chk("read only", adr(3, `A_PER), 32'h0);
  endtask

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    nrst           = 1'b0;
    ce             = 1'b1;
    avs_address    = 7'h00;
    avs_read       = 1'b0;
    avs_write      = 1'b0;
    avs_writedata  = 32'h0;
    avs_byteenable = 4'hF;
    gen_en         = 8'h00;
    gen_idle       = 8'h00;
    for (int i = 0; i < 8; i++) begin
      gen_per[i] = 16'h000A;
      gen_hi[i]  = 16'h0005;
    end
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    t_reset();
    t_modes();
    t_duty();
    t_freq();
    t_edge();
    t_count();
    t_clear();
    end_sim();
  end

  // guards against a hang outside the bounded bus waits
  initial begin
    #500000;
    err_total++;
    $display("Error run time expected end seen limit");
    end_sim();
  end
endmodule
`default_nettype wire
